// ---- verilog/boundary_scan_config_interlock.sv ----
// Test access port with configuration interlock, boundary cells and Wishbone registers.
`default_nettype none
module boundary_scan_config_interlock (
	input  wire logic                        clk_i,             // System clock.
	input  wire logic                        rst_i,             // Synchronous reset.
	input  wire boundary_scan_pkg::jtag_in_s jtag_i,            // TCK, TMS, TDI pins.
	output logic                             tdo_o,             // Test data out.
	output logic                             tdo_oe_o,          // TDO driven.
	input  wire logic                        config_restart_n_i, // Restart pin, low holds.
	input  wire logic [3:0]                  pin_i,             // Pad input levels.
	output logic      [3:0]                  pin_o,             // Pad output value.
	output logic      [3:0]                  pin_oe_o,          // Pad driven.
	input  wire logic [3:0]                  core_out_i,        // Core output data.
	input  wire logic [3:0]                  core_oe_i,         // Core output enable.
	input  wire logic [3:0]                  core_out_only_i,   // Pin used as output only.
	output logic                             config_done_o,     // Configuration complete.
	output logic                             status_low_o,      // Status pin pulled low.
	input  wire logic                        wb_cyc_i,          // Wishbone cycle.
	input  wire logic                        wb_stb_i,          // Wishbone strobe.
	input  wire logic                        wb_we_i,           // Wishbone write.
	input  wire logic [7:0]                  wb_adr_i,          // Byte address.
	input  wire logic [3:0]                  wb_sel_i,          // Byte selects.
	input  wire logic [31:0]                 wb_dat_i,          // Write data.
	output logic      [31:0]                 wb_dat_o,          // Read data.
	output logic                             wb_ack_o           // Acknowledge.
);
	localparam int NP = boundary_scan_pkg::NUM_PINS;

	// ----------------------------------------------------------------
	// Pin synchronisation and TCK edge detection
	// ----------------------------------------------------------------
	logic [NP+3:0] sync_q;
	logic          tck_s, tms_s, tdi_s, restart_s, tck_d;
	logic [NP-1:0] pin_s;
	sync_two_stage #(.W(NP + 4)) u_sync (
		.clk_i (clk_i),
		.d_i   ({jtag_i.tck, jtag_i.tms, jtag_i.tdi, config_restart_n_i, pin_i}),
		.q_o   (sync_q)
	);
	assign {tck_s, tms_s, tdi_s, restart_s, pin_s} = sync_q;
	wire tck_rise = tck_s & ~tck_d;
	wire tck_fall = ~tck_s & tck_d;

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	boundary_scan_pkg::tap_e tap, next_tap;
	boundary_scan_pkg::cfg_e cfg, next_cfg;
	logic [9:0]  ir, next_ir, ir_sh, next_ir_sh;
	logic [31:0] dr_sh, next_dr_sh, dr_cap;
	logic        next_tdo, next_tdo_oe;
	logic [NP-1:0] output_enable_update_cell, next_oe_cell;
	logic [NP-1:0] output_data_update_cell, next_out_cell;
	logic [7:0]  iocsr, next_iocsr;
	logic [boundary_scan_pkg::CFG_CNT_W-1:0] cnt, next_cnt;
	logic        always_inbuf, next_always_inbuf, sw_start, wr;
	logic        next_ack;
	logic [31:0] next_dat;
	logic [NP-1:0] inbuf_en, pin_cap, next_pin, next_pin_oe;
	logic [NP-1:0] bsr_oe_sh, bsr_out_sh;
	logic [boundary_scan_pkg::BSR_LEN-1:0] bsr_cap;
	int          dr_len;

	wire busy     = (cfg == boundary_scan_pkg::CFG_RUN);
	wire ir_upd   = tck_rise && (tap == boundary_scan_pkg::UPD_IR);
	wire halt_cmd = ir_upd && (ir_sh == boundary_scan_pkg::INS_CONFIG_IO ||
		ir_sh == boundary_scan_pkg::INS_ACTIVE_CONFIG_RELEASE);
	// While configuring, only the halt instructions and those that cannot disturb it are let through.
	wire ir_ok = !busy || halt_cmd || ir_sh == boundary_scan_pkg::INS_BYPASS ||
		ir_sh == boundary_scan_pkg::INS_IDCODE || ir_sh == boundary_scan_pkg::INS_SAMPLE;
	wire extest = (ir == boundary_scan_pkg::INS_EXTEST);
	wire sel_bsr = extest || ir == boundary_scan_pkg::INS_SAMPLE;

	// TAP controller transitions on TMS.
	function automatic boundary_scan_pkg::tap_e tap_step(boundary_scan_pkg::tap_e s,
		logic m);
		unique case (s)
			boundary_scan_pkg::TEST_RESET: tap_step = m ? boundary_scan_pkg::TEST_RESET : boundary_scan_pkg::RUN_IDLE;
			boundary_scan_pkg::RUN_IDLE: tap_step = m ? boundary_scan_pkg::SEL_DR : boundary_scan_pkg::RUN_IDLE;
			boundary_scan_pkg::SEL_DR: tap_step = m ? boundary_scan_pkg::SEL_IR : boundary_scan_pkg::CAP_DR;
			boundary_scan_pkg::CAP_DR: tap_step = m ? boundary_scan_pkg::EX1_DR : boundary_scan_pkg::SH_DR;
			boundary_scan_pkg::SH_DR: tap_step = m ? boundary_scan_pkg::EX1_DR : boundary_scan_pkg::SH_DR;
			boundary_scan_pkg::EX1_DR: tap_step = m ? boundary_scan_pkg::UPD_DR : boundary_scan_pkg::PAU_DR;
			boundary_scan_pkg::PAU_DR: tap_step = m ? boundary_scan_pkg::EX2_DR : boundary_scan_pkg::PAU_DR;
			boundary_scan_pkg::EX2_DR: tap_step = m ? boundary_scan_pkg::UPD_DR : boundary_scan_pkg::SH_DR;
			boundary_scan_pkg::UPD_DR: tap_step = m ? boundary_scan_pkg::SEL_DR : boundary_scan_pkg::RUN_IDLE;
			boundary_scan_pkg::SEL_IR: tap_step = m ? boundary_scan_pkg::TEST_RESET : boundary_scan_pkg::CAP_IR;
			boundary_scan_pkg::CAP_IR: tap_step = m ? boundary_scan_pkg::EX1_IR : boundary_scan_pkg::SH_IR;
			boundary_scan_pkg::SH_IR: tap_step = m ? boundary_scan_pkg::EX1_IR : boundary_scan_pkg::SH_IR;
			boundary_scan_pkg::EX1_IR: tap_step = m ? boundary_scan_pkg::UPD_IR : boundary_scan_pkg::PAU_IR;
			boundary_scan_pkg::PAU_IR: tap_step = m ? boundary_scan_pkg::EX2_IR : boundary_scan_pkg::PAU_IR;
			boundary_scan_pkg::EX2_IR: tap_step = m ? boundary_scan_pkg::UPD_IR : boundary_scan_pkg::SH_IR;
			boundary_scan_pkg::UPD_IR: tap_step = m ? boundary_scan_pkg::SEL_DR : boundary_scan_pkg::RUN_IDLE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Per-pin boundary cells and input buffers
	// ----------------------------------------------------------------
	for (genvar k = 0; k < NP; k++) begin : g_pin
		// Output-only pins lose their input buffer once configured, unless sampling or always_inbuf is set.
		assign inbuf_en[k] = (cfg != boundary_scan_pkg::CFG_DONE) || !core_out_only_i[k] ||
			always_inbuf || (ir == boundary_scan_pkg::INS_SAMPLE);
		assign pin_cap[k] = pin_s[k] & inbuf_en[k];
		assign bsr_cap[3*k+2:3*k] = {pin_o[k], ~pin_oe_o[k], pin_cap[k]};
		assign bsr_oe_sh[k]  = dr_sh[3*k+1];
		assign bsr_out_sh[k] = dr_sh[3*k+2];
		// Cell value 0 drives the data cell, 1 floats the pad.
		assign next_pin[k]    = extest ? output_data_update_cell[k] : core_out_i[k];
		assign next_pin_oe[k] = extest ? ~output_enable_update_cell[k] :
			(cfg == boundary_scan_pkg::CFG_DONE) && core_oe_i[k];
	end

	// Register selected by the current instruction, with its length.
	always_comb begin
		dr_len = 1;
		dr_cap = 32'h0000_0000;
		if (ir == boundary_scan_pkg::INS_IDCODE) begin
			dr_len = boundary_scan_pkg::ID_LEN;
			dr_cap = {boundary_scan_pkg::IDCODE_VALUE[31:1], 1'b1};
		end else if (sel_bsr) begin
			dr_len = boundary_scan_pkg::BSR_LEN;
			dr_cap = {20'h0_0000, bsr_cap};
		end else if (ir == boundary_scan_pkg::INS_CONFIG_IO) begin
			dr_len = boundary_scan_pkg::IOCSR_LEN;
			dr_cap = {24'h00_0000, iocsr};
		end
	end

	// ----------------------------------------------------------------
	// TAP group: always live, nothing in the register map can stop it
	// ----------------------------------------------------------------
	always_comb begin
		next_tap      = tap;
		next_ir       = ir;
		next_ir_sh    = ir_sh;
		next_dr_sh    = dr_sh;
		next_tdo      = tdo_o;
		next_tdo_oe   = tdo_oe_o;
		next_oe_cell  = output_enable_update_cell;
		next_out_cell = output_data_update_cell;
		next_iocsr    = iocsr;
		if (tck_rise) begin
			next_tap = tap_step(tap, tms_s);
			case (tap)
				boundary_scan_pkg::CAP_IR: next_ir_sh = boundary_scan_pkg::IR_CAPTURE;
				boundary_scan_pkg::SH_IR: next_ir_sh = {tdi_s, ir_sh[9:1]};
				// Blocked codes fall back to bypass so configuration is untouched.
				boundary_scan_pkg::UPD_IR: next_ir = ir_ok ? ir_sh : boundary_scan_pkg::INS_BYPASS;
				boundary_scan_pkg::CAP_DR: next_dr_sh = dr_cap;
				boundary_scan_pkg::SH_DR: begin
					next_dr_sh = {1'b0, dr_sh[31:1]};
					next_dr_sh[dr_len-1] = tdi_s;
				end
				boundary_scan_pkg::UPD_DR: begin
					if (sel_bsr) begin
						next_oe_cell  = bsr_oe_sh;
						next_out_cell = bsr_out_sh;
					end
					// I/O settings arrive serially under the I/O instruction.
					if (ir == boundary_scan_pkg::INS_CONFIG_IO) begin
						next_iocsr = dr_sh[7:0];
					end
				end
				default: ;
			endcase
		end
		if (tck_fall) begin
			next_tdo    = (tap == boundary_scan_pkg::SH_IR) ? ir_sh[0] : dr_sh[0];
			next_tdo_oe = (tap == boundary_scan_pkg::SH_IR) || (tap == boundary_scan_pkg::SH_DR);
		end
		if (tap == boundary_scan_pkg::TEST_RESET) begin
			next_ir = boundary_scan_pkg::IR_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tap   <= boundary_scan_pkg::TEST_RESET;
			ir    <= boundary_scan_pkg::IR_RESET;
			ir_sh <= boundary_scan_pkg::IR_CAPTURE;
			dr_sh <= 32'h0000_0000;
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
			output_enable_update_cell <= 4'hF;
			output_data_update_cell   <= 4'h0;
			iocsr <= boundary_scan_pkg::IOCSR_RESET;
			tck_d <= 1'b0;
		end else begin
			tap   <= next_tap;
			ir    <= next_ir;
			ir_sh <= next_ir_sh;
			dr_sh <= next_dr_sh;
			tdo_o <= next_tdo;
			tdo_oe_o <= next_tdo_oe;
			output_enable_update_cell <= next_oe_cell;
			output_data_update_cell   <= next_out_cell;
			iocsr <= next_iocsr;
			tck_d <= tck_s;
		end
	end

	// ----------------------------------------------------------------
	// Configuration sequencer
	// ----------------------------------------------------------------
	// A low restart pin holds the sequencer; a halted load waits for a restart.
	always_comb begin
		next_cfg = cfg;
		next_cnt = cnt;
		unique case (cfg)
			boundary_scan_pkg::CFG_WAIT: begin
				next_cfg = boundary_scan_pkg::CFG_RUN;
				next_cnt = '0;
			end
			boundary_scan_pkg::CFG_RUN: begin
				if (halt_cmd) begin
					next_cfg = boundary_scan_pkg::CFG_HALT;
				end else if (cnt == (boundary_scan_pkg::CFG_CNT_W)'(boundary_scan_pkg::CFG_CYCLES - 1)) begin
					next_cfg = boundary_scan_pkg::CFG_DONE;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			boundary_scan_pkg::CFG_DONE, boundary_scan_pkg::CFG_HALT: begin
				if (sw_start || (ir_upd && ir_sh == boundary_scan_pkg::INS_RECONFIG)) begin
					next_cfg = boundary_scan_pkg::CFG_RUN;
					next_cnt = '0;
				end
			end
		endcase
		if (!restart_s) begin
			next_cfg = boundary_scan_pkg::CFG_WAIT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= boundary_scan_pkg::CFG_WAIT;
			cnt <= '0;
			config_done_o <= 1'b0;
			status_low_o  <= 1'b0;
			pin_o    <= 4'h0;
			pin_oe_o <= 4'h0;
		end else begin
			cfg <= next_cfg;
			cnt <= next_cnt;
			config_done_o <= (next_cfg == boundary_scan_pkg::CFG_DONE);
			status_low_o  <= (ir == boundary_scan_pkg::INS_CONFIG_IO);
			pin_o    <= next_pin;
			pin_oe_o <= next_pin_oe;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Writes land on the acknowledge cycle; unmapped addresses read zero.
	assign wr       = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	assign sw_start = wr && wb_adr_i == boundary_scan_pkg::ADDR_CTRL &&
		wb_dat_i[boundary_scan_pkg::CTRL_START_BIT];
	always_comb begin
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_always_inbuf = always_inbuf;
		next_dat = 32'h0000_0000;
		if (wr && wb_adr_i == boundary_scan_pkg::ADDR_CTRL) begin
			next_always_inbuf = wb_dat_i[boundary_scan_pkg::CTRL_INBUF_BIT];
		end
		unique case (wb_adr_i)
			boundary_scan_pkg::ADDR_CTRL: next_dat[boundary_scan_pkg::CTRL_INBUF_BIT] = always_inbuf;
			boundary_scan_pkg::ADDR_STATUS: begin
				next_dat[boundary_scan_pkg::ST_BUSY_BIT] = busy;
				next_dat[boundary_scan_pkg::ST_HALT_BIT] = (cfg == boundary_scan_pkg::CFG_HALT);
				next_dat[boundary_scan_pkg::ST_DONE_BIT] = (cfg == boundary_scan_pkg::CFG_DONE);
				next_dat[boundary_scan_pkg::ST_IR_LSB +: 10] = ir;
			end
			boundary_scan_pkg::ADDR_IOCSR: next_dat[7:0] = iocsr;
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			always_inbuf <= boundary_scan_pkg::CTRL_INBUF_RESET;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			always_inbuf <= next_always_inbuf;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_IR_CAPTURE: assert property (tck_rise && tap == boundary_scan_pkg::CAP_IR |=> ##1
		(ir_sh == 10'h2AA) && (!tck_fall || tap != boundary_scan_pkg::SH_IR || next_tdo == 1'b0))
		else $error("Instruction capture did not load the checkerboard.");
	AST_BYPASS_LEN: assert property (ir == 10'h3FF |-> dr_len == 1 && dr_cap == 32'h0000_0000)
		else $error("All-ones instruction did not select bypass.");
	AST_IDCODE_LSB: assert property (tck_rise && tap == boundary_scan_pkg::CAP_DR &&
		ir == boundary_scan_pkg::INS_IDCODE |=> dr_sh[0] == 1'b1 && dr_len == 32)
		else $error("Identification word lost its fixed one.");
	AST_EXTEST_DRIVE: assert property (extest && $stable(ir) |=>
		((pin_oe_o ^ ~$past(output_enable_update_cell)) == 4'h0) &&
		(((pin_o ^ $past(output_data_update_cell)) & pin_oe_o) == 4'h0))
		else $error("External test pin does not follow its update cells.");
	AST_CELL_HIZ: assert property (extest |=> (pin_oe_o & $past(output_enable_update_cell)) == 4'h0)
		else $error("Pad driven while its enable cell holds one.");
	AST_RUN_UNDISTURBED: assert property (busy && ir_upd && !halt_cmd && restart_s &&
		int'(cnt) < boundary_scan_pkg::CFG_CYCLES - 1 |=> busy && ir != boundary_scan_pkg::INS_EXTEST)
		else $error("Configuration disturbed by an instruction.");
	AST_IO_HALTS: assert property (busy && ir_upd && ir_sh == boundary_scan_pkg::INS_CONFIG_IO &&
		restart_s |=> cfg == boundary_scan_pkg::CFG_HALT ##1 status_low_o)
		else $error("I/O reconfiguration did not halt configuration.");
	AST_HALT_HOLDS: assert property (cfg == boundary_scan_pkg::CFG_HALT && restart_s && !sw_start &&
		!(ir_upd && ir_sh == boundary_scan_pkg::INS_RECONFIG) |=> cfg == boundary_scan_pkg::CFG_HALT)
		else $error("Halted configuration resumed on its own.");
	AST_SAMPLE_INBUF: assert property (ir == boundary_scan_pkg::INS_SAMPLE || always_inbuf |->
		inbuf_en == 4'hF)
		else $error("Input buffer off while it must be on.");
	AST_OUTONLY_OFF: assert property (cfg == boundary_scan_pkg::CFG_DONE && !always_inbuf &&
		ir != boundary_scan_pkg::INS_SAMPLE |-> (inbuf_en & core_out_only_i) == 4'h0)
		else $error("Output-only input buffer on in a configured part.");
	AST_TAP_LIVE: assert property (tck_rise && tap == boundary_scan_pkg::RUN_IDLE && tms_s |=>
		tap == boundary_scan_pkg::SEL_DR)
		else $error("TAP controller did not advance.");
endmodule
`default_nettype wire

// ---- verilog/boundary_scan_pkg.sv ----
// Constants, codes and carrier types for the boundary-scan configuration interlock.
// How it works
// - The test port runs from reset on its own pins and no software setting can switch it off.
// - While configuration runs, bypass, identification and sample are accepted without upsetting it.
// - The I/O reconfiguration instruction interrupts configuration and loads I/O settings serially.
// - On a configured part output-only pins have input buffers off, except under sample.
// - A software option keeps every input buffer on, as on an unconfigured part.
// - Capture into the instruction register loads 1010101010, seen on TDO from the first shift.
// - Under external test a pin with its output-enable cell at 0 drives its output-data cell.
// - Under external test a pin whose output-enable cell holds 1 has its output buffer in high impedance.
// - An all-ones instruction selects the single-bit bypass path.
// - Identification loads a 32-bit word whose least significant bit is one.
`default_nettype none
package boundary_scan_pkg;
	// ----------------------------------------------------------------
	// Sizes and codes
	// ----------------------------------------------------------------
	localparam int          NUM_PINS     = 4;
	localparam int          IR_LEN       = 10;
	localparam int          BSR_LEN      = 3 * NUM_PINS;
	localparam int          IOCSR_LEN    = 8;
	localparam int          ID_LEN       = 32;
	localparam logic [9:0]  IR_CAPTURE   = 10'h2AA;
	localparam logic [9:0]  INS_EXTEST   = 10'h000;
	localparam logic [9:0]  INS_RECONFIG = 10'h001;
	localparam logic [9:0]  INS_SAMPLE   = 10'h005;
	localparam logic [9:0]  INS_IDCODE   = 10'h006;
	localparam logic [9:0]  INS_CONFIG_IO = 10'h00D;
	localparam logic [9:0]  INS_ACTIVE_CONFIG_RELEASE = 10'h2D0;
	localparam logic [9:0]  INS_BYPASS   = 10'h3FF;
	localparam logic [9:0]  IR_RESET     = INS_IDCODE;
	// Arbitrary identification value; bit 0 is forced to one anyway.
	localparam logic [31:0] IDCODE_VALUE = 32'h0A5C_3001;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          CFG_TIME_NS   = 10000;
	localparam int          CFG_CYCLES    = CFG_TIME_NS * 1000 / CLK_PERIOD_PS;
	localparam int          CFG_CNT_W     = 12;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  ADDR_IOCSR   = 8'h08;
	localparam int          CTRL_INBUF_BIT = 0;
	localparam int          CTRL_START_BIT = 1;
	localparam logic        CTRL_INBUF_RESET = 1'b0;
	localparam int          ST_BUSY_BIT  = 0;
	localparam int          ST_HALT_BIT  = 1;
	localparam int          ST_DONE_BIT  = 2;
	localparam int          ST_IR_LSB    = 16;
	localparam logic [7:0]  IOCSR_RESET  = 8'h00;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtag_in_s;
	typedef enum logic [3:0] {
		TEST_RESET = 4'h0, RUN_IDLE = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
		SH_DR = 4'h6, EX1_DR = 4'h7, PAU_DR = 4'h5, EX2_DR = 4'h4,
		UPD_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SH_IR = 4'hE,
		EX1_IR = 4'hA, PAU_IR = 4'hB, EX2_IR = 4'h9, UPD_IR = 4'h8
	} tap_e;
	typedef enum logic [1:0] {
		CFG_WAIT = 2'b00, CFG_RUN = 2'b01, CFG_DONE = 2'b11, CFG_HALT = 2'b10
	} cfg_e;
endpackage
`default_nettype wire

// ---- verilog/sync_two_stage.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`default_nettype none
module sync_two_stage #(
	parameter int W = 1
) (
	input  wire logic         clk_i, // System clock.
	input  wire logic [W-1:0] d_i,   // Asynchronous levels.
	output logic      [W-1:0] q_o    // Synchronised levels.
);
	logic [W-1:0] meta;
	// The first stage feeds only the second, so metastability stays contained.
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o  <= meta;
	end
endmodule
`default_nettype wire

// ---- verification/jtag_tester_model.sv ----
// Behavioural boundary-scan tester that drives the link pins and samples test data out.
`default_nettype none
module jtag_tester_model (
	output var boundary_scan_pkg::jtag_in_s jtag_o, // TCK, TMS and TDI to the device.
	input  wire logic                       tdo_i   // Test data out from the device.
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Link clock
	// ----------------------------------------------------------------
	// TCK stands low between frames; pins change while it is low.
	initial jtag_o = '0;
	// One 48 ns bit: TDO is taken just before the rise, after the previous fall.
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		jtag_o.tms <= tms;
		jtag_o.tdi <= tdi;
		#24 tdo = tdo_i;
		jtag_o.tck <= 1'b1;
		#24 jtag_o.tck <= 1'b0;
	endtask
	// Five high TMS bits reach the reset state; a low one parks in idle.
	task automatic tap_reset();
		logic d;
		repeat (5) tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b1, d);
	endtask
	// From idle: capture, shift n bits LSB first, update, back to idle.
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic d;
		dout = '0;
		tick(1'b1, 1'b0, d);
		if (ir) tick(1'b1, 1'b1, d);
		tick(1'b0, 1'b0, d);
		tick(1'b0, 1'b1, d);
		for (int i = 0; i < n; i++) begin
			tick(1'(i == n - 1), din[i], d);
			dout[i] = d;
		end
		tick(1'b1, ~din[0], d);
		tick(1'b0, din[0], d);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench: link scans and register accesses against the interlock.
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, restart_n = 1'b1, cyc = 1'b0, we = 1'b0;
	logic [3:0]  pin_in = 4'hF, c_out = 4'h5, c_oe = 4'hF, out_only = 4'h1, pin_out, pin_oe;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat, rd, sh;
	logic        tdo, tdo_oe, done, st_low, ack;
	boundary_scan_pkg::jtag_in_s jtag;
	int          error_cnt = 0, check_count = 0;
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	boundary_scan_config_interlock boundary_scan_config_interlock_inst (.clk_i(clk_i),
		.rst_i(rst_i), .jtag_i(jtag), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
		.config_restart_n_i(restart_n), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe),
		.core_out_i(c_out), .core_oe_i(c_oe), .core_out_only_i(out_only),
		.config_done_o(done), .status_low_o(st_low), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack));
	// A released TDO shows the inverse of its last bit, so a late or missing enable is caught.
	jtag_tester_model jtag_tester_model_inst (.jtag_o(jtag), .tdo_i(tdo_oe ? tdo : ~tdo));
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Classic single Wishbone cycle; the request holds until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (int i = 0; i <= 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
			if (i == 20) begin
				error_cnt++;
				test_done();
			end
		end
		rd = rdat;
		cyc <= 1'b0;
	endtask
	task automatic ir(input logic [9:0] c);
		jtag_tester_model_inst.scan(1'b1, 10, {22'h0, c}, sh);
	endtask
	task automatic dr(input int n, input logic [31:0] d);
		jtag_tester_model_inst.scan(1'b0, n, d, sh);
	endtask
	// Waits a bounded time for configuration to finish; a miss ends the run.
	task automatic wait_done();
		for (int i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clk_i);
		if (done !== 1'b1) begin
			error_cnt++;
			test_done();
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	// The early scans finish well inside the configuration run time.
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		jtag_tester_model_inst.tap_reset();
		ir(boundary_scan_pkg::INS_IDCODE);
		`CHK(sh[9:0], boundary_scan_pkg::IR_CAPTURE)
		dr(32, 32'h0000_0000);
		`CHK(sh, {boundary_scan_pkg::IDCODE_VALUE[31:1], 1'b1})
		ir(boundary_scan_pkg::INS_BYPASS);
		dr(8, 32'h0000_00A5);
		`CHK(sh[7:0], 8'h4A)
		wb(1'b0, boundary_scan_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[2:0], 3'h1)
		$display("test running scans done");
		ir(boundary_scan_pkg::INS_CONFIG_IO);
		`CHK(st_low, 1'b1)
		dr(8, 32'h0000_005A);
		wb(1'b0, boundary_scan_pkg::ADDR_IOCSR, 32'h0000_0000);
		`CHK(rd[7:0], 8'h5A)
		repeat (2500) @(posedge clk_i);
		wb(1'b0, boundary_scan_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[2:0], 3'h2)
		ir(boundary_scan_pkg::INS_SAMPLE);
		dr(12, 32'h0000_0484);
		ir(boundary_scan_pkg::INS_EXTEST);
		`CHK(pin_oe, 4'h3)
		`CHK(pin_out[1:0], 2'h1)
		$display("test interrupt done");
		ir(boundary_scan_pkg::INS_RECONFIG);
		wait_done();
		ir(boundary_scan_pkg::INS_EXTEST);
		dr(12, 32'h0000_0484);
		`CHK({sh[3], sh[0]}, 2'h2)
		ir(boundary_scan_pkg::INS_SAMPLE);
		dr(12, 32'h0000_0484);
		`CHK({sh[3], sh[0]}, 2'h3)
		wb(1'b1, boundary_scan_pkg::ADDR_CTRL, 32'h0000_0001);
		ir(boundary_scan_pkg::INS_EXTEST);
		dr(12, 32'h0000_0484);
		`CHK({sh[3], sh[0]}, 2'h3)
		$display("test input buffers done");
		wb(1'b1, boundary_scan_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
		wb(1'b0, 8'hF0, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		wb(1'b0, boundary_scan_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[2:0], 3'h1)
		ir(boundary_scan_pkg::INS_BYPASS);
		`CHK(sh[9:0], boundary_scan_pkg::IR_CAPTURE)
		restart_n <= 1'b0;
		ir(boundary_scan_pkg::INS_IDCODE);
		`CHK(sh[9:0], boundary_scan_pkg::IR_CAPTURE)
		wb(1'b0, boundary_scan_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[2:0], 3'h0)
		restart_n <= 1'b1;
		ir(boundary_scan_pkg::INS_ACTIVE_CONFIG_RELEASE);
		wb(1'b0, boundary_scan_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK(rd[2:0], 3'h2)
		ir(boundary_scan_pkg::INS_RECONFIG);
		wait_done();
		$display("test restart done");
		test_done();
	end
endmodule
`default_nettype wire
